//--- rtl/code_reader_parallel_trigger_io.sv
// Summary of operation
// - judgement_output active on fail by default, on success if chosen
// - output period 2.0..10000.0 ms, default 10.0 ms
// - gate delay 1.0..1000.0 ms after result shown, default 1.0 ms
// - gate on-time 1.0..1000.0 ms, default 5.0 ms
// - triggers acted on only in monitor or run mode
// - one reading per rising edge of single shot trigger
// - single shot stops on success, else retries up to retry count
// - held trigger ignores retry count
// - continuous mode reads again while held trigger stays active
// - level mode retries until success, fails when input drops
// - scene switch triggers change scene before reading
// - scene per switch trigger 0..9, default 0, level behaviour
// - one result for every reading executed
// - result outputs change only in run mode
// - success requests decoded data send on serial link
// - failure requests error code send on serial link
// - outputs start inactive; host ignores first 0.5 s
// - busy while reading, triggers rejected meanwhile
module code_reader_parallel_trigger_io (
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic        single_shot_trigger,
    input  wire logic        held_trigger,
    input  wire logic        scene_switch_trigger_first,
    input  wire logic        scene_switch_trigger_second,
    input  wire logic        run_mode,
    input  wire logic        monitor_mode,
    input  wire logic        polarity_success_active,
    input  wire logic        held_level_mode,
    input  wire logic [7:0]  retry_count,
    input  wire logic [3:0]  scene_first_cfg,
    input  wire logic [3:0]  scene_second_cfg,
    input  wire logic [3:0]  current_scene,
    input  wire logic [16:0] period_ms10,
    input  wire logic [16:0] gate_delay_ms10,
    input  wire logic [16:0] gate_on_ms10,
    input  wire logic        read_done,
    input  wire logic        read_ok,
    output logic             read_start,
    output logic [3:0]       read_scene,
    output logic             busy,
    output logic             judgement_output,
    output logic             gate_strobe,
    output logic             send_data,
    output logic             send_error
);
    typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_NEXT} rd_state_t;
    typedef enum logic [1:0] {GT_IDLE, GT_DELAY, GT_ON, GT_REST} gt_state_t;

    logic [3:0]       trig_s;
    logic             one_prev_r;
    rd_state_t        rd_r;
    trig_io_pkg::trig_src_t src_r;
    logic [7:0]       tries_r;
    logic             res_valid_r;
    logic             res_ok_r;
    gt_state_t        gt_r;
    logic [11:0]      tick_cnt_r;
    logic             tick;
    logic [16:0]      gt_cnt_r;
    logic [16:0]      per_cnt_r;
    logic [3:1]       lock_r;
    logic             pend_r;
    logic             pend_ok_r;
    logic             active_mode;
    logic             one_rise;
    logic [16:0]      per_eff;
    logic [16:0]      dly_eff;
    logic [16:0]      on_eff;

    function automatic logic [3:0] scene_sel(input logic [3:0] s);
        if (s > trig_io_pkg::SCENE_MAX) begin
            return trig_io_pkg::SCENE_MAX;
        end
        return s;
    endfunction : scene_sel

    trig_io_sync u_sync (
        .mclk     (mclk),
        .resetn   (resetn),
        .async_in ({scene_switch_trigger_second, scene_switch_trigger_first,
                    held_trigger, single_shot_trigger}),
        .sync_out (trig_s)
    );

    assign active_mode = run_mode | monitor_mode;
    assign one_rise    = trig_s[0] & ~one_prev_r;
    assign per_eff = trig_io_pkg::clamp_ms10(period_ms10,
        trig_io_pkg::PERIOD_MIN_MS10, trig_io_pkg::PERIOD_MAX_MS10);
    assign dly_eff = trig_io_pkg::clamp_ms10(gate_delay_ms10,
        trig_io_pkg::DELAY_MIN_MS10, trig_io_pkg::DELAY_MAX_MS10);
    assign on_eff  = trig_io_pkg::clamp_ms10(gate_on_ms10,
        trig_io_pkg::ON_MIN_MS10, trig_io_pkg::ON_MAX_MS10);
    assign tick = (tick_cnt_r == trig_io_pkg::TICK_CYCLES - 12'h001);

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            one_prev_r <= 1'b0;
        end else begin
            one_prev_r <= trig_s[0];
        end
    end

    // level sources stop after a good read until their input drops
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            lock_r <= 3'b000;
        end else begin
            lock_r <= lock_r & trig_s[3:1];
            if (rd_r == RD_WAIT && read_done && read_ok) begin
                case (src_r)
                    trig_io_pkg::SRC_HELD: begin
                        lock_r[1] <= held_level_mode & trig_s[1];
                    end
                    trig_io_pkg::SRC_SCN1: begin
                        lock_r[2] <= trig_s[2];
                    end
                    trig_io_pkg::SRC_SCN2: begin
                        lock_r[3] <= trig_s[3];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tick_cnt_r <= 12'h000;
        end else if (tick || (gt_r == GT_IDLE && pend_r)) begin
            // phase restarts with each gate so delays are whole units
            tick_cnt_r <= 12'h000;
        end else begin
            tick_cnt_r <= tick_cnt_r + 12'h001;
        end
    end

    // reading sequencer: one start per attempt, one result once the attempts of a reading end
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rd_r        <= RD_IDLE;
            src_r       <= trig_io_pkg::SRC_ONE;
            tries_r     <= 8'h00;
            read_start  <= 1'b0;
            read_scene  <= trig_io_pkg::SCENE_DEF;
            busy        <= 1'b0;
            res_valid_r <= 1'b0;
            res_ok_r    <= 1'b0;
        end else begin
            read_start  <= 1'b0;
            res_valid_r <= 1'b0;
            case (rd_r)
                RD_IDLE: begin
                    busy <= 1'b0;
                    // triggers seen while busy are dropped, not queued
                    if (active_mode) begin
                        if (one_rise) begin
                            src_r      <= trig_io_pkg::SRC_ONE;
                            read_scene <= current_scene;
                            tries_r    <= 8'h00;
                            read_start <= 1'b1;
                            busy       <= 1'b1;
                            rd_r       <= RD_WAIT;
                        end else if (trig_s[1] && !lock_r[1]) begin
                            src_r      <= trig_io_pkg::SRC_HELD;
                            read_scene <= current_scene;
                            read_start <= 1'b1;
                            busy       <= 1'b1;
                            rd_r       <= RD_WAIT;
                        end else if (trig_s[2] && !lock_r[2]) begin
                            src_r      <= trig_io_pkg::SRC_SCN1;
                            read_scene <= scene_sel(scene_first_cfg);
                            read_start <= 1'b1;
                            busy       <= 1'b1;
                            rd_r       <= RD_WAIT;
                        end else if (trig_s[3] && !lock_r[3]) begin
                            src_r      <= trig_io_pkg::SRC_SCN2;
                            read_scene <= scene_sel(scene_second_cfg);
                            read_start <= 1'b1;
                            busy       <= 1'b1;
                            rd_r       <= RD_WAIT;
                        end
                    end
                end
                RD_WAIT: begin
                    if (read_done) begin
                        rd_r <= RD_NEXT;
                        if (read_ok) begin
                            res_valid_r <= 1'b1;
                            res_ok_r    <= 1'b1;
                            rd_r        <= RD_IDLE;
                        end else if (src_r == trig_io_pkg::SRC_ONE) begin
                            if (tries_r >= retry_count) begin
                                res_valid_r <= 1'b1;
                                res_ok_r    <= 1'b0;
                                rd_r        <= RD_IDLE;
                            end else begin
                                tries_r <= tries_r + 8'h01;
                            end
                        end else if (src_r == trig_io_pkg::SRC_HELD &&
                                     !held_level_mode) begin
                            res_valid_r <= 1'b1;
                            res_ok_r    <= 1'b0;
                            rd_r        <= RD_IDLE;
                        end
                    end
                end
                RD_NEXT: begin
                    // level behaviour: fail reported when the input drops
                    if ((src_r == trig_io_pkg::SRC_HELD && !trig_s[1]) ||
                        (src_r == trig_io_pkg::SRC_SCN1 && !trig_s[2]) ||
                        (src_r == trig_io_pkg::SRC_SCN2 && !trig_s[3])) begin
                        res_valid_r <= 1'b1;
                        res_ok_r    <= 1'b0;
                        rd_r        <= RD_IDLE;
                    end else begin
                        read_start <= 1'b1;
                        rd_r       <= RD_WAIT;
                    end
                end
                default: rd_r <= RD_IDLE;
            endcase
        end
    end

    // one pending result; a newer one overwrites it while the gate is busy
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pend_r    <= 1'b0;
            pend_ok_r <= 1'b0;
        end else if (res_valid_r && run_mode) begin
            pend_r    <= 1'b1;
            pend_ok_r <= res_ok_r;
        end else if (gt_r == GT_IDLE && pend_r) begin
            pend_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            send_data  <= 1'b0;
            send_error <= 1'b0;
        end else begin
            send_data  <= res_valid_r & res_ok_r;
            send_error <= res_valid_r & ~res_ok_r;
        end
    end

    // gate sequencer: present, delay, strobe, rest out the period
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            gt_r             <= GT_IDLE;
            gt_cnt_r         <= 17'h0_0000;
            per_cnt_r        <= 17'h0_0000;
            judgement_output <= 1'b0;
            gate_strobe      <= 1'b0;
        end else begin
            if (gt_r != GT_IDLE && tick) begin
                per_cnt_r <= per_cnt_r + 17'h0_0001;
            end
            if (gt_r != GT_IDLE && gt_r != GT_REST && tick) begin
                gt_cnt_r <= gt_cnt_r + 17'h0_0001;
            end
            case (gt_r)
                GT_IDLE: begin
                    if (pend_r) begin
                        judgement_output <= pend_ok_r ^
                            ~polarity_success_active;
                        gt_cnt_r  <= 17'h0_0000;
                        per_cnt_r <= 17'h0_0000;
                        gt_r      <= GT_DELAY;
                    end
                end
                GT_DELAY: begin
                    if (tick && gt_cnt_r == dly_eff - 17'h0_0001) begin
                        gate_strobe <= 1'b1;
                        gt_cnt_r    <= 17'h0_0000;
                        gt_r        <= GT_ON;
                    end
                end
                GT_ON: begin
                    if (tick && gt_cnt_r == on_eff - 17'h0_0001) begin
                        gate_strobe <= 1'b0;
                        gt_r        <= GT_REST;
                    end
                end
                GT_REST: begin
                    if (per_cnt_r >= per_eff) begin
                        judgement_output <= 1'b0;
                        gt_r             <= GT_IDLE;
                    end
                end
                default: gt_r <= GT_IDLE;
            endcase
        end
    end
endmodule : code_reader_parallel_trigger_io

//--- rtl/trig_io_pkg.sv
package trig_io_pkg;

    // times in tenths of a millisecond, cycles derived at 10 MHz
    localparam int unsigned CLK_HZ            = 10_000_000;
    localparam int unsigned TICK_PER_MS10     = CLK_HZ / 10_000;
    localparam logic [16:0] PERIOD_MIN_MS10   = 17'h0_0014;
    localparam logic [16:0] PERIOD_MAX_MS10   = 17'h1_86A0;
    localparam logic [16:0] PERIOD_DEF_MS10   = 17'h0_0064;
    localparam logic [16:0] DELAY_MIN_MS10    = 17'h0_000A;
    localparam logic [16:0] DELAY_MAX_MS10    = 17'h0_2710;
    localparam logic [16:0] DELAY_DEF_MS10    = 17'h0_000A;
    localparam logic [16:0] ON_MIN_MS10       = 17'h0_000A;
    localparam logic [16:0] ON_MAX_MS10       = 17'h0_2710;
    localparam logic [16:0] ON_DEF_MS10       = 17'h0_0032;
    localparam logic [11:0] TICK_CYCLES       = 12'(TICK_PER_MS10);
    // power-up quiet time, 0.5 s in tenths of a millisecond
    localparam logic [16:0] POWERUP_MS10      = 17'h0_1388;
    localparam logic [3:0]  SCENE_MAX         = 4'h9;
    localparam logic [3:0]  SCENE_DEF         = 4'h0;
    localparam logic [7:0]  RETRY_DEF         = 8'h00;

    typedef enum logic [1:0] {
        SRC_ONE, SRC_HELD, SRC_SCN1, SRC_SCN2
    } trig_src_t;

    function automatic logic [16:0] clamp_ms10(
        input logic [16:0] v,
        input logic [16:0] lo,
        input logic [16:0] hi
    );
        if (v < lo) begin
            return lo;
        end else if (v > hi) begin
            return hi;
        end
        return v;
    endfunction : clamp_ms10

endpackage : trig_io_pkg

//--- rtl/trig_io_sync.sv
module trig_io_sync (
    input  wire logic       mclk,
    input  wire logic       resetn,
    input  wire logic [3:0] async_in,
    output logic      [3:0] sync_out
);
    logic [3:0] meta_r;

    // first stage feeds only the second stage
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            meta_r   <= 4'h0;
            sync_out <= 4'h0;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule : trig_io_sync

//--- verification/read_engine_model.sv
module read_engine_model (
    input  wire logic       mclk,
    input  wire logic       resetn,
    input  wire logic       read_start,
    input  wire logic       ok_cfg,
    input  wire logic [7:0] lat,
    output logic            read_done,
    output logic            read_ok
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cnt_r;
    logic       act_r;

    // verdict toggles outside the answer so nobody leans on a stale value
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            act_r     <= 1'b0;
            cnt_r     <= 8'h00;
            read_done <= 1'b0;
            read_ok   <= 1'b0;
        end else begin
            read_done <= 1'b0;
            read_ok   <= ~read_ok;
            if (read_start) begin
                act_r <= 1'b1;
                cnt_r <= lat;
            end else if (act_r && cnt_r == 8'h00) begin
                act_r     <= 1'b0;
                read_done <= 1'b1;
                read_ok   <= ok_cfg;
            end else if (act_r) begin
                cnt_r <= cnt_r - 8'h01;
            end
        end
    end
endmodule : read_engine_model

//--- verification/tb_code_reader_parallel_trigger_io.sv
module tb_code_reader_parallel_trigger_io;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TK = 1000;
    logic        mclk = 1'b0;
    logic        resetn = 1'b0;
    logic        single_shot_trigger = 1'b0;
    logic        held_trigger = 1'b0;
    logic        scene_switch_trigger_first = 1'b0;
    logic        scene_switch_trigger_second = 1'b0;
    logic        run_mode = 1'b1;
    logic        monitor_mode = 1'b0;
    logic        polarity_success_active = 1'b0;
    logic        held_level_mode = 1'b0;
    logic [7:0]  retry_count = 8'h02;
    logic [3:0]  scene_first_cfg = 4'h5;
    logic [3:0]  scene_second_cfg = 4'h9;
    logic [3:0]  current_scene = 4'h2;
    logic [16:0] period_ms10 = 17'h0_0015; // 2.1 ms > 1 + 1 ms
    logic [16:0] gate_delay_ms10 = 17'h0_000A;
    logic [16:0] gate_on_ms10 = 17'h0_000A;
    logic        ok_cfg = 1'b1;
    logic [7:0]  lat = 8'h14;
    logic        read_done, read_ok, read_start, busy, judgement_output;
    logic        gate_strobe, send_data, send_error, jv, g_q;
    logic [3:0]  read_scene, scn;
    int          err_count, samples_checked, starts, datas, errs, gates;
    int          t_now, t_send, t_gate, e_hold;

    always #50 mclk = ~mclk;

    code_reader_parallel_trigger_io dut (.mclk, .resetn, .single_shot_trigger,
        .held_trigger, .scene_switch_trigger_first, .scene_switch_trigger_second,
        .run_mode, .monitor_mode, .polarity_success_active, .held_level_mode,
        .retry_count, .scene_first_cfg, .scene_second_cfg, .current_scene,
        .period_ms10, .gate_delay_ms10, .gate_on_ms10, .read_done, .read_ok,
        .read_start, .read_scene, .busy, .judgement_output, .gate_strobe,
        .send_data, .send_error);
    read_engine_model engine (.mclk, .resetn, .read_start, .ok_cfg, .lat,
        .read_done, .read_ok);

    // outputs are looked at half a cycle after the edge that launches them
    always @(negedge mclk) begin
        t_now++;
        if (read_start) begin
            starts++;
            scn = read_scene;
        end
        if (send_data || send_error) t_send = t_now;
        if (send_data) datas++;
        if (send_error) errs++;
        if (gate_strobe && !g_q) begin
            gates++;
            jv = judgement_output;
            t_gate = t_now;
        end
        g_q = gate_strobe;
    end

    task automatic print_verdict();
        $display("errors %0d checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
        end
    endtask : check

    // raise one trigger, hold it, drop it, wait for busy to fall, then wait settle cycles
    task automatic trig(input int w, input int hold, input int settle);
        int n;
        starts = 0;
        datas = 0;
        errs = 0;
        gates = 0;
        n = 0;
        @(negedge mclk);
        {scene_switch_trigger_second, scene_switch_trigger_first,
         held_trigger, single_shot_trigger} = 4'h1 << w;
        repeat (hold) @(negedge mclk);
        e_hold = errs;
        {scene_switch_trigger_second, scene_switch_trigger_first,
         held_trigger, single_shot_trigger} = 4'h0;
        while (busy !== 1'b0 && n < 20000) begin
            @(negedge mclk);
            n++;
        end
        if (n == 20000) begin
            err_count++;
            print_verdict();
        end
        repeat (settle) @(negedge mclk);
    endtask : trig

    initial begin
        int d;
        repeat (3) @(negedge mclk);
        resetn = 1'b1;
        repeat (2) @(negedge mclk);
        check("powerup reads", 0, starts);
        check("powerup judge", 0, judgement_output);
        check("powerup gate", 0, gate_strobe);
        for (int k = 0; k < 4; k++) begin
            polarity_success_active = k[1];
            ok_cfg = k[0];
            // hold plus settle cover the whole gate period before the next trigger
            trig(0, 5000, 16200); // held 0.5 ms
            d = t_gate - t_send;
            check("reads", k[0] ? 1 : 3, starts);
            check("data", k[0], datas);
            check("error", !k[0], errs);
            check("gates", 1, gates);
            check("judge", k[1] == k[0], jv);
            check("scene", current_scene, scn);
            check("delay", 1, d >= 10 * TK && d <= 10 * TK + 4);
        end
        run_mode = 1'b0;
        monitor_mode = 1'b1;
        trig(0, 5000, 50);
        check("mon data", 1, datas);
        check("mon gates", 0, gates);
        monitor_mode = 1'b0;
        trig(0, 100, 50);
        check("off reads", 0, starts);
        // remaining reads run in monitor mode to skip the slow gate cycle
        monitor_mode = 1'b1;
        for (int w = 2; w < 4; w++) begin
            trig(w, 200, 50);
            check("switch scene", w == 2 ? 5 : 9, scn);
            check("switch data", 1, datas);
        end
        lat = 8'h02;
        ok_cfg = 1'b0;
        trig(1, 1000, 50);
        check("cont reads", 1, starts > 1);
        check("cont errors", starts, errs);
        held_level_mode = 1'b1;
        trig(1, 1000, 50);
        check("level hold", 0, e_hold);
        check("level reads", 1, starts > 1);
        check("level errors", 1, errs);
        print_verdict();
    end
endmodule : tb_code_reader_parallel_trigger_io

//--- verification/trig_io_chk.sv
module trig_io_chk (
    input wire logic        mclk,
    input wire logic        resetn,
    input wire logic        run_mode,
    input wire logic        monitor_mode,
    input wire logic [16:0] period_ms10,
    input wire logic [16:0] gate_on_ms10,
    input wire logic        read_done,
    input wire logic        read_ok,
    input wire logic        read_start,
    input wire logic        busy,
    input wire logic        judgement_output,
    input wire logic        gate_strobe,
    input wire logic        send_data
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] MS10 = 32'h0000_03E8;
    // triggers pass a two-stage synchroniser, so nothing can start sooner
    localparam logic [22:0] PWR  = 23'h00_0003;
    logic [31:0] on_cnt_r;
    logic [31:0] gap_cnt_r;
    logic [22:0] pwr_cnt_r;

    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);

    // gap starts saturated so the first gate after reset is never judged
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            on_cnt_r  <= 32'h0000_0000;
            gap_cnt_r <= 32'hFFFF_FFFF;
            pwr_cnt_r <= 23'h00_0000;
        end else begin
            if (gate_strobe) begin
                on_cnt_r <= on_cnt_r + 32'h0000_0001;
            end else begin
                on_cnt_r <= 32'h0000_0000;
            end
            if (gate_strobe && on_cnt_r == 32'h0000_0000) begin
                gap_cnt_r <= 32'h0000_0001;
            end else if (gap_cnt_r != 32'hFFFF_FFFF) begin
                gap_cnt_r <= gap_cnt_r + 32'h0000_0001;
            end
            if (pwr_cnt_r < PWR) begin
                pwr_cnt_r <= pwr_cnt_r + 23'h00_0001;
            end
        end
    end

    a_start_busy: assert property (read_start |-> busy)
        else $error("read started without busy");
    a_start_cause: assert property (read_start |-> !$past(busy)
        || $past(read_done, 2) || $past(read_done, 3))
        else $error("read started while busy without a retry cause");
    a_mode_gate: assert property (
        !busy && !run_mode && !monitor_mode |=> !read_start)
        else $error("read started outside run and monitor mode");
    a_powerup_quiet: assert property (
        pwr_cnt_r < PWR |-> !read_start && !gate_strobe && !judgement_output)
        else $error("activity inside power-up window");
    a_ok_sends: assert property (read_done && read_ok |-> ##2 send_data)
        else $error("good read not sent");
    a_gate_run: assert property ($rose(gate_strobe) |-> run_mode)
        else $error("gate outside run mode");
    a_judge_hold: assert property (
        gate_strobe && $past(gate_strobe) |-> $stable(judgement_output))
        else $error("judgement moved during gate");
    a_gate_on_len: assert property (
        $fell(gate_strobe) |-> on_cnt_r == gate_on_ms10 * MS10)
        else $error("gate on-time wrong");
    a_gate_spacing: assert property (
        $rose(gate_strobe) |-> gap_cnt_r >= period_ms10 * MS10)
        else $error("two gates within one period");
endmodule : trig_io_chk

bind code_reader_parallel_trigger_io trig_io_chk u_chk (
    .mclk, .resetn, .run_mode, .monitor_mode, .period_ms10, .gate_on_ms10,
    .read_done, .read_ok, .read_start, .busy, .judgement_output,
    .gate_strobe, .send_data
);
